/* logic/ee_dev.sv */
// eeprom end: start/stop detection, select match, byte write with inhibit
`timescale 1ns/1ns
`include "ee_defs.svh"
module ee_dev import ee_pkg::*; #(
    parameter int unsigned PROG_CYCLES = `EE_T_WR_NS / `EE_LINK_NS
) (
    input wire logic i_link_clock,
    input wire logic i_link_rstn,
    ee_if.dev bus,
    input wire logic i_chip_sel_bit2,
    input wire logic i_chip_sel_bit1,
    input wire logic i_chip_sel_bit0,
    input wire logic i_write_inhibit,
    output logic o_prog_start,
    output logic [10:0] o_prog_addr,
    output logic [7:0] o_prog_data,
    output logic o_busy
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [5:0] pins_s; // scl, sda, chip selects, inhibit
    logic s_scl; // synchronised clock line
    logic s_sda; // synchronised data line
    logic [2:0] s_cs; // synchronised chip select pins
    logic s_wi; // synchronised write inhibit

    ee_sync #(.W(6)) u_sync (
        .i_clock(i_link_clock),
        .i_rstn(i_link_rstn),
        .i_async({bus.scl, bus.sda, i_chip_sel_bit2, i_chip_sel_bit1,
                  i_chip_sel_bit0, i_write_inhibit}),
        .o_sync(pins_s)
    );
    assign {s_scl, s_sda, s_cs, s_wi} = pins_s;

    // ----------------------------------------
    // state
    // ----------------------------------------
    ee_dev_st_t st_q, st_d; // sequencer
    logic scl_p_q; // clock line one sample ago
    logic sda_p_q; // data line one sample ago
    logic [7:0] sh_q, sh_d; // received byte, msb first
    logic [3:0] bit_q, bit_d; // bits taken in this byte
    logic slot_q, slot_d; // inside the ninth bit time
    logic drive_q, drive_d; // pulling data low
    logic inh_q, inh_d; // inhibit seen since start
    logic got_q, got_d; // data byte accepted for programming
    logic nack_q, nack_d; // master's last read answer
    logic [2:0] hi_q, hi_d; // upper three address bits
    logic [7:0] addr_q, addr_d; // byte address
    logic [7:0] data_q, data_d; // byte to program
    logic [31:0] cnt_q, cnt_d; // programming cycle counter
    logic pstart_d; // next programming start pulse

    // ----------------------------------------
    // bus event decode
    // ----------------------------------------
    wire scl_rise = s_scl & ~scl_p_q;
    wire scl_fall = ~s_scl & scl_p_q;
    wire start_det = scl_p_q & s_scl & sda_p_q & ~s_sda;
    wire stop_det = scl_p_q & s_scl & ~sda_p_q & s_sda;
    wire rx_st = (st_q == D_SEL) | (st_q == D_ADDR) | (st_q == D_DATA);
    wire byte_full = (bit_q == `EE_BITS_PER_BYTE);
    wire take_bit = scl_rise & ~byte_full & (rx_st | (st_q == D_READ));
    wire byte_done = rx_st & scl_fall & byte_full & ~slot_q;
    wire slot_end = rx_st & scl_fall & slot_q;
    wire sel_match = (sh_q[`EE_SEL_B7] == `EE_SEL_FIXED) &
                     (sh_q[`EE_SEL_CS_HI:`EE_SEL_CS_LO] == s_cs);
    wire wr_ok = ~(inh_q | s_wi);
    wire prog_end = (cnt_q == 32'(PROG_CYCLES - 1));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        slot_d = slot_q;
        drive_d = drive_q;
        inh_d = inh_q;
        got_d = got_q;
        nack_d = nack_q;
        hi_d = hi_q;
        addr_d = addr_q;
        data_d = data_q;
        cnt_d = '0;
        pstart_d = 1'b0;
        if (st_q == D_PROG) begin
            // deaf to the bus, so polls are nacked
            cnt_d = cnt_q + 32'h0000_0001;
            if (prog_end) begin
                st_d = D_IDLE;
                cnt_d = '0;
            end
        end else if (start_det) begin
            // any start, also a repeated one, opens a new select
            st_d = D_SEL;
            bit_d = '0;
            slot_d = 1'b0;
            drive_d = 1'b0;
            inh_d = s_wi;
            got_d = 1'b0;
            nack_d = 1'b0;
        end else if (stop_det) begin
            slot_d = 1'b0;
            drive_d = 1'b0;
            if (got_q) begin
                st_d = D_PROG;
                pstart_d = 1'b1;
            end else if (st_q == D_READ && !nack_q) begin
                st_d = D_WAIT;
            end else begin
                st_d = D_IDLE;
            end
        end else begin
            // inhibit is watched until the last data ack slot
            if (rx_st) begin
                inh_d = inh_q | s_wi;
            end
            // shift in on the clock rise, msb first
            if (take_bit) begin
                sh_d = {sh_q[6:0], s_sda};
                bit_d = bit_q + 4'h1;
            end
            // read: device sends all ones, note the master's answer
            if (st_q == D_READ && scl_rise && byte_full) begin
                nack_d = s_sda;
                bit_d = '0;
            end
            // after eight bits decide whether to pull low in slot nine
            if (byte_done) begin
                slot_d = 1'b1;
                case (st_q)
                    D_SEL: begin
                        drive_d = sel_match;
                        hi_d = sh_q[`EE_SEL_AH_HI:`EE_SEL_AH_LO];
                    end
                    D_ADDR: begin
                        drive_d = 1'b1;
                        addr_d = sh_q;
                    end
                    D_DATA: begin
                        drive_d = wr_ok;
                        if (wr_ok) begin
                            data_d = sh_q;
                            got_d = 1'b1;
                        end
                    end
                    default: begin
                        drive_d = 1'b0;
                    end
                endcase
            end
            // end of the ninth pulse: release and move on
            if (slot_end) begin
                slot_d = 1'b0;
                drive_d = 1'b0;
                bit_d = '0;
                case (st_q)
                    D_SEL: begin
                        if (!drive_q) begin
                            st_d = D_WAIT;
                        end else if (sh_q[`EE_SEL_RW] == `EE_RW_READ) begin
                            st_d = D_READ;
                        end else begin
                            st_d = D_ADDR;
                        end
                    end
                    D_ADDR: begin
                        st_d = D_DATA;
                    end
                    default: begin
                        st_d = D_WAIT; // single byte write, wait for stop
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_link_clock) begin
        if (!i_link_rstn) begin
            st_q <= D_IDLE;
            scl_p_q <= 1'b0;
            sda_p_q <= 1'b0;
            sh_q <= '0;
            bit_q <= '0;
            slot_q <= 1'b0;
            drive_q <= 1'b0;
            inh_q <= 1'b0;
            got_q <= 1'b0;
            nack_q <= 1'b0;
            hi_q <= '0;
            addr_q <= '0;
            data_q <= '0;
            cnt_q <= '0;
            o_prog_start <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            st_q <= st_d;
            scl_p_q <= s_scl;
            sda_p_q <= s_sda;
            sh_q <= sh_d;
            bit_q <= bit_d;
            slot_q <= slot_d;
            drive_q <= drive_d;
            inh_q <= inh_d;
            got_q <= got_d;
            nack_q <= nack_d;
            hi_q <= hi_d;
            addr_q <= addr_d;
            data_q <= data_d;
            cnt_q <= cnt_d;
            o_prog_start <= pstart_d;
            o_busy <= (st_d == D_PROG);
        end
    end

    // ----------------------------------------
    // outputs, open drain: only ever pulls low
    // ----------------------------------------
    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = drive_q;
    assign o_prog_addr = {hi_q, addr_q};
    assign o_prog_data = data_q;
endmodule // ee_dev

/* logic/ee_mst.sv */
// bus master end: byte write and select polling over the two-wire link
`timescale 1ns/1ns
`include "ee_defs.svh"
module ee_mst import ee_pkg::*; #(
    parameter int QTR = `EE_QTR_CYC
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic i_poll,
    input wire logic [2:0] i_sel,
    input wire logic [10:0] i_addr,
    input wire logic [7:0] i_data,
    output logic o_busy,
    output logic o_done,
    output logic [2:0] o_acks,
    ee_if.mst bus
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    ee_mst_st_t st_q; // sequencer
    logic [15:0] qcnt_q; // quarter bit divider
    logic [1:0] ph_q; // quarter within a bit
    logic [3:0] bit_q; // bit of the byte, eight is the ack slot
    logic [1:0] byte_q; // byte index
    logic [1:0] last_q; // index of the final byte
    logic [7:0] sh_q; // byte being sent, msb first
    logic scl_q; // clock line level
    logic low_q; // pulling data low
    logic poll_q; // request is a poll
    logic [2:0] sel_q; // chip select code
    logic [10:0] addr_q; // target location
    logic [7:0] data_q; // byte to write
    logic s_sda; // synchronised data line

    ee_sync #(.W(1)) u_sync (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_async(bus.sda),
        .o_sync(s_sda)
    );

    // byte to send at a given index: select, address, data
    function automatic logic [7:0] byte_of(input logic [1:0] idx);
        case (idx)
            2'h0: byte_of = {`EE_SEL_FIXED, sel_q, addr_q[10:8], `EE_RW_WRITE};
            2'h1: byte_of = addr_q[7:0];
            default: byte_of = data_q;
        endcase
    endfunction

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire tick = (qcnt_q == 16'(QTR - 1));
    wire in_ack = (bit_q == `EE_BITS_PER_BYTE);
    wire byte_end = (st_q == M_BIT) & tick & (ph_q == 2'h3) & in_ack;
    wire got_ack = ~s_sda;
    wire go_stop = ~o_acks[byte_q] | (byte_q == last_q);

    // ----------------------------------------
    // divider and sequencer; data moves with clock low, except at start and stop where it moves with clock high
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            st_q <= M_IDLE;
            qcnt_q <= '0;
            ph_q <= '0;
            bit_q <= '0;
            byte_q <= '0;
            last_q <= '0;
            sh_q <= '0;
            scl_q <= 1'b1;
            low_q <= 1'b0;
            poll_q <= 1'b0;
            sel_q <= '0;
            addr_q <= '0;
            data_q <= '0;
            o_done <= 1'b0;
            o_acks <= '0;
        end else begin
            o_done <= 1'b0;
            qcnt_q <= (tick || st_q == M_IDLE) ? '0 : qcnt_q + 16'h0001;
            if (st_q != M_IDLE && tick) begin
                ph_q <= ph_q + 2'h1;
            end
            case (st_q)
                M_IDLE: begin
                    ph_q <= '0;
                    if (i_req) begin
                        st_q <= M_START;
                        poll_q <= i_poll;
                        last_q <= i_poll ? 2'h0 : 2'h2;
                        sel_q <= i_sel;
                        addr_q <= i_addr;
                        data_q <= i_data;
                        o_acks <= '0;
                    end
                end
                M_START: begin
                    if (tick && ph_q == 2'h1) begin
                        low_q <= 1'b1; // data falls, clock high
                    end
                    if (tick && ph_q == 2'h2) begin
                        scl_q <= 1'b0;
                        st_q <= M_BIT;
                        ph_q <= '0;
                        bit_q <= '0;
                        byte_q <= '0;
                        sh_q <= byte_of(2'h0);
                    end
                end
                M_BIT: begin
                    if (tick) begin
                        case (ph_q)
                            2'h0: low_q <= in_ack ? 1'b0 : ~sh_q[7];
                            2'h1: scl_q <= 1'b1;
                            2'h2: if (in_ack) o_acks[byte_q] <= got_ack;
                            default: scl_q <= 1'b0;
                        endcase
                    end
                    if (tick && ph_q == 2'h3 && !in_ack) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (byte_end) begin
                        bit_q <= '0;
                        if (go_stop) begin
                            st_q <= M_STOP;
                        end else begin
                            byte_q <= byte_q + 2'h1;
                            sh_q <= byte_of(byte_q + 2'h1);
                        end
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        case (ph_q)
                            2'h0: low_q <= 1'b1;
                            2'h1: scl_q <= 1'b1;
                            2'h2: low_q <= 1'b0; // data rises, clock high
                            default: begin
                                st_q <= M_IDLE;
                                o_done <= 1'b1;
                            end
                        endcase
                    end
                end
                default: st_q <= M_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_busy = (st_q != M_IDLE);
    assign bus.scl = scl_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = low_q;
endmodule // ee_mst

/* logic/ee_sync.sv */
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
module ee_sync #(
    parameter int W = 1
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q; // first stage, read only by the second

    // ----------------------------------------
    // two stages, cleared to zero in reset
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // ee_sync

/* shared/ee_defs.svh */
// constants for the serial eeprom slave front end and its bus master
`ifndef EE_DEFS_SVH
`define EE_DEFS_SVH
// ----------------------------------------
// select byte layout
// ----------------------------------------
`define EE_SEL_FIXED 1'h1
`define EE_SEL_B7 7
`define EE_SEL_CS_HI 6
`define EE_SEL_CS_LO 4
`define EE_SEL_AH_HI 3
`define EE_SEL_AH_LO 1
`define EE_SEL_RW 0
`define EE_RW_READ 1'h1
`define EE_RW_WRITE 1'h0
`define EE_BITS_PER_BYTE 4'h8
// ----------------------------------------
// timing
// ----------------------------------------
`define EE_T_WR_NS 5000000
`define EE_LINK_NS 15
`define EE_CLK_NS 20
`define EE_T_QTR_NS 700
`define EE_QTR_CYC ((`EE_T_QTR_NS + `EE_CLK_NS - 1) / `EE_CLK_NS)
`endif

/* shared/ee_if.sv */
// two-wire bus between the master end and the eeprom end
`timescale 1ns/1ns
interface ee_if;
    logic scl; // serial clock, driven by the master only
    logic sda_m_o; // master data out
    logic sda_m_oe; // master drives data line
    logic sda_s_o; // slave data out
    logic sda_s_oe; // slave drives data line
    logic sda; // resolved line, pulled up when nobody pulls low
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
    modport mst (output scl, output sda_m_o, output sda_m_oe, input sda);
    modport dev (input scl, output sda_s_o, output sda_s_oe, input sda);
endinterface

/* shared/ee_pkg.sv */
// types shared by both ends of the two-wire eeprom link
package ee_pkg;
    // device side sequencer states
    typedef enum logic [2:0] {
        D_IDLE, D_SEL, D_ADDR, D_DATA, D_READ, D_WAIT, D_PROG
    } ee_dev_st_t;
    // master side sequencer states
    typedef enum logic [1:0] {
        M_IDLE, M_START, M_BIT, M_STOP
    } ee_mst_st_t;
endpackage

/* test/ee_link_sva.sv */
// assertions on the two-wire link, sampled in the eeprom clock domain
`timescale 1ns/1ns
module ee_link_sva (
    input wire logic i_link_clock,
    input wire logic i_link_rstn,
    input wire logic scl,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic sda
);
    default clocking @(posedge i_link_clock); endclocking
    default disable iff (!i_link_rstn);
    // ----------------------------------------
    // frame tracking helpers
    // ----------------------------------------
    logic scl_q; // line levels one link cycle ago
    logic sda_q;
    logic active_q; // between a start and a stop
    logic [3:0] cnt_q; // clock rises since start or since the last ack slot
    logic [1:0] byte_q; // bytes finished in this frame
    logic [7:0] sh_q; // bits taken in on clock rises
    wire start_w = scl_q & scl & sda_q & ~sda;
    wire stop_w = scl_q & scl & ~sda_q & sda;
    wire rise_w = ~scl_q & scl;
    // follow the line the way a listener would
    always_ff @(posedge i_link_clock) begin
        if (!i_link_rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            active_q <= 1'b0;
            cnt_q <= 4'h0;
            byte_q <= 2'h0;
            sh_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            active_q <= start_w | (active_q & ~stop_w);
            cnt_q <= start_w ? 4'h0 : (rise_w ? ((cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1) : cnt_q);
            byte_q <= start_w ? 2'h0
                : byte_q + {1'b0, rise_w & (cnt_q == 4'h8) & (byte_q != 2'h3)};
            sh_q <= (rise_w & (cnt_q != 4'h8)) ? {sh_q[6:0], sda} : sh_q;
        end
    end
    // ----------------------------------------
    // device side of the link
    // ----------------------------------------
    property p_open_drain; sda_s_oe |-> !sda_s_o; endproperty
    a_open_drain: assert property (p_open_drain) else $error("slave drives line high");
    property p_ack_ninth; $rose(sda_s_oe) |-> cnt_q == 4'h8 && !scl; endproperty
    a_ack_ninth: assert property (p_ack_ninth) else $error("ack not in ninth slot");
    property p_ack_held; $rose(sda_s_oe) |-> sda_s_oe [*8]; endproperty
    a_ack_held: assert property (p_ack_held) else $error("ack pulse too short");
    property p_ack_ends; $rose(sda_s_oe) |-> ##[1:100] !sda_s_oe; endproperty
    a_ack_ends: assert property (p_ack_ends) else $error("ack never released");
    property p_release; $fell(sda_s_oe) |-> cnt_q == 4'h0 && !scl; endproperty
    a_release: assert property (p_release) else $error("ack released off slot");
    property p_after_start; sda_s_oe |-> active_q; endproperty
    a_after_start: assert property (p_after_start) else $error("slave drives outside frame");
    property p_quiet_high; scl && $past(scl) |-> $stable(sda_s_oe); endproperty
    a_quiet_high: assert property (p_quiet_high) else $error("slave moves line, clock high");
    property p_sel_b7; $rose(sda_s_oe) && byte_q == 2'h0 |-> sh_q[7]; endproperty
    a_sel_b7: assert property (p_sel_b7) else $error("select acked with top bit zero");
endmodule // ee_link_sva

/* test/test_serial_eeprom_i2c_slave_write.sv */
// self-checking bench: eeprom end and bus master end joined over the link
`timescale 1ns/1ns
module test_serial_eeprom_i2c_slave_write;
    localparam int PROG = 2000; // shortened programming cycle, link cycles
    localparam int LIMIT = 60000; // clock cycles before a hang is cut short
    logic clock, rstn, link_clock, link_rstn;
    logic req, poll, wi;
    logic [2:0] sel, pins, acks;
    logic [10:0] addr, prog_addr;
    logic [7:0] data, prog_data;
    logic busy, done, prog_start, dev_busy;
    logic [2:0] exp_acks[$]; // ack patterns still to come
    logic [18:0] exp_prog[$]; // {location, byte} still to be programmed
    logic [18:0] exp_p; // oldest programming note, unknown when none is due
    int busy_len; // link cycles the eeprom end has spent programming
    int bad_count, comparisons, cycles;
    int seed = 32'h424f_ebe1;
    ee_if link_bus();
    ee_mst #(.QTR(8)) i_ee_mst (.i_clock(clock), .i_rstn(rstn), .i_req(req), .i_poll(poll),
        .i_sel(sel), .i_addr(addr), .i_data(data), .o_busy(busy), .o_done(done),
        .o_acks(acks), .bus(link_bus));
    ee_dev #(.PROG_CYCLES(PROG)) i_ee_dev (.i_link_clock(link_clock), .i_link_rstn(link_rstn),
        .bus(link_bus), .i_chip_sel_bit2(pins[2]), .i_chip_sel_bit1(pins[1]),
        .i_chip_sel_bit0(pins[0]), .i_write_inhibit(wi), .o_prog_start(prog_start),
        .o_prog_addr(prog_addr), .o_prog_data(prog_data), .o_busy(dev_busy));
    ee_link_sva u_sva (.i_link_clock(link_clock), .i_link_rstn(link_rstn), .scl(link_bus.scl),
        .sda_s_o(link_bus.sda_s_o), .sda_s_oe(link_bus.sda_s_oe), .sda(link_bus.sda));
    // ----------------------------------------
    // clocks: 20 ns system, 15 ns link with its own phase
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        link_clock = 1'b0;
        #6;
        forever begin
            #7 link_clock = 1'b1;
            #8 link_clock = 1'b0;
        end
    end
    // ----------------------------------------
    // verdict, compares and watchers
    // ----------------------------------------
    task automatic stop_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_acks(input logic [2:0] e, input logic [2:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error acks expected %h seen %h", e, g);
        end
    endtask
    task automatic chk_prog(input logic [18:0] e, input logic [18:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error prog expected %h seen %h", e, g);
        end
    endtask
    task automatic chk_busy(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error busy expected %h seen %h", e, g);
        end
    endtask
    // an empty queue yields unknown, so an unasked result is a mismatch
    always @(negedge clock) begin
        if (done === 1'b1) begin
            chk_acks(exp_acks.size() > 0 ? exp_acks.pop_front() : 3'bxxx, acks);
        end
    end
    always @(negedge link_clock) begin
        if (prog_start === 1'b1) begin
            exp_p = exp_prog.size() > 0 ? exp_prog.pop_front() : 19'bx;
            chk_prog(exp_p, {prog_addr, prog_data});
        end
    end
    // programming busy must last exactly the configured number of link cycles
    always @(negedge link_clock) begin
        if (dev_busy === 1'b1) begin
            busy_len++;
        end else if (busy_len != 0) begin
            chk_busy(32'(PROG), 32'(busy_len));
            busy_len = 0;
        end
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            stop_test();
        end
    end
    // ----------------------------------------
    // drivers
    // ----------------------------------------
    // one master request; w > 0 holds inhibit high for w+1 cycles from the request
    task automatic xfer(input logic p, input logic [2:0] s, input logic [2:0] ea, input logic pe,
                        input int w);
        int n;
        @(posedge clock);
        #1;
        req = 1'b1;
        poll = p;
        sel = s;
        addr = 11'($random(seed));
        data = 8'($random(seed));
        if (w > 0) begin
            wi = 1'b1;
        end
        exp_acks.push_back(ea);
        if (pe) begin
            exp_prog.push_back({addr, data});
        end
        @(posedge clock);
        #1;
        req = 1'b0;
        chk_busy(32'h0000_0001, 32'(busy));
        if (w > 0) begin
            repeat (w) @(posedge clock);
            #1;
            wi = 1'b0;
        end
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge clock);
            #1;
            n++;
        end
        repeat (10) @(posedge clock);
        #1;
    endtask
    // wait out the programming cycle
    task automatic idle_wait();
        int n;
        n = 0;
        while (dev_busy !== 1'b0 && n < 3000) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {req, poll, wi, sel, addr, data} = '0;
        pins = 3'h5;
        {rstn, link_rstn} = 2'b00;
        {bad_count, comparisons, cycles} = '0;
        repeat (8) @(posedge clock);
        #1;
        {rstn, link_rstn} = 2'b11;
        repeat (5) @(posedge clock);
        #1;
        // every chip-select code with a matching select byte
        for (int i = 0; i < 8; i++) begin
            pins = 3'(i);
            xfer(1'b0, pins, 3'h7, 1'b1, 0);
            idle_wait();
        end
        // write, poll while programming, poll once ready
        xfer(1'b0, pins, 3'h7, 1'b1, 0);
        xfer(1'b1, pins, 3'h0, 1'b0, 0);
        idle_wait();
        xfer(1'b1, pins, 3'h1, 1'b0, 0);
        // select code of another device
        xfer(1'b0, pins ^ (3'h1 | 3'($random(seed))), 3'h0, 1'b0, 0);
        // inhibit held all through, briefly at start, and into the data byte
        wi = 1'b1;
        xfer(1'b0, pins, 3'h3, 1'b0, 0);
        wi = 1'b0;
        xfer(1'b0, pins, 3'h3, 1'b0, 40);
        xfer(1'b0, pins, 3'h3, 1'b0, 700);
        xfer(1'b0, pins, 3'h7, 1'b1, 0);
        idle_wait();
        if (exp_acks.size() != 0 || exp_prog.size() != 0) begin
            bad_count++;
            $display("Error pending expected 0 seen %0d", exp_acks.size() + exp_prog.size());
        end
        stop_test();
    end
endmodule // test_serial_eeprom_i2c_slave_write
